// ---- core/hsi_top.sv ----
// Purpose: HDLC event flags, enable mask and active-low interrupt for one framer.
// Assumes: Control port strobes and HDLC engine events are synchronous to mclk.
// Notes: Reading the flag register clears the three latched flags; a new event
//        in the same cycle as that read survives it.
`timescale 1ns/1ns
`default_nettype none
module hsi_top
    import hsi_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic port_rd,
    input wire logic port_wr,
    input wire logic [7:0] port_addr,
    input wire logic [7:0] port_wdata,
    output logic [7:0] port_rdata,
    input wire logic rx_open_byte,
    input wire logic rx_frame_good,
    input wire logic rx_frame_fault,
    input wire logic tx_frame_sent,
    input wire logic [6:0] rx_level,
    input wire logic [6:0] tx_level,
    output logic int_n
);

    typedef struct packed {
        logic [6:0] enable;
        logic pkt_start;
        logic pkt_end;
        logic msg_end;
        logic [7:0] rdata;
        logic int_n;
    } hsi_state_s;

    hsi_state_s st_q;
    hsi_state_s st_d;

    logic lvl_rx_half;
    logic lvl_rx_ne;
    logic lvl_tx_half;
    logic lvl_tx_nf;
    logic [6:0] flag_vec;
    logic rd_flags;
    logic wr_enable;
    logic [6:0] gated;

    // Occupancy-driven flags live in their own small module
    hsi_level_flags u_level (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .rx_level(rx_level),
        .tx_level(tx_level),
        .rx_half_full(lvl_rx_half),
        .rx_not_empty(lvl_rx_ne),
        .tx_half_empty(lvl_tx_half),
        .tx_not_full(lvl_tx_nf)
    );

    // Address decode, used for reads, writes and read-clear
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
        hit = (addr == target);
    endfunction

    assign rd_flags = ce && port_rd && hit(port_addr, HSI_ADDR_FLAGS);
    assign wr_enable = ce && port_wr && hit(port_addr, HSI_ADDR_ENABLE);

    // Live view of the flag register, bit 7 always zero
    always_comb begin
        flag_vec = '0;
        flag_vec[HSI_BIT_RX_PKT_END] = st_q.pkt_end;
        flag_vec[HSI_BIT_RX_PKT_START] = st_q.pkt_start;
        flag_vec[HSI_BIT_RX_HALF_FULL] = lvl_rx_half;
        flag_vec[HSI_BIT_RX_NOT_EMPTY] = lvl_rx_ne;
        flag_vec[HSI_BIT_TX_HALF_EMPTY] = lvl_tx_half;
        flag_vec[HSI_BIT_TX_NOT_FULL] = lvl_tx_nf;
        flag_vec[HSI_BIT_TX_MSG_END] = st_q.msg_end;
    end

    // Per-flag gate; one mask bit per event source
    for (genvar g = 0; g < HSI_NUM_FLAGS; g++) begin : g_gate
        assign gated[g] = flag_vec[g] & st_q.enable[g];
    end

    // Next state; everything holds while ce is low
    always_comb begin
        st_d = st_q;
        if (ce) begin
            // Set beats clear so an event landing on the read is not lost
            st_d.pkt_start = rx_open_byte | (st_q.pkt_start & ~rd_flags);
            st_d.pkt_end = rx_frame_good | rx_frame_fault | (st_q.pkt_end & ~rd_flags);
            st_d.msg_end = tx_frame_sent | (st_q.msg_end & ~rd_flags);
            if (wr_enable) begin
                st_d.enable = port_wdata[6:0];
            end
            // Read data captured at the strobe and held until the next read
            if (port_rd) begin
                if (hit(port_addr, HSI_ADDR_FLAGS)) begin
                    st_d.rdata = {1'b0, flag_vec};
                end else if (hit(port_addr, HSI_ADDR_ENABLE)) begin
                    st_d.rdata = {1'b0, st_q.enable};
                end else begin
                    st_d.rdata = 8'h00;
                end
            end
            // Pin follows the gated flags one cycle late; a read that clears the
            // last enabled latched flag releases it on the following edge
            st_d.int_n = ~|gated;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st_q.enable <= HSI_ENABLE_RST;
            st_q.pkt_start <= 1'b0;
            st_q.pkt_end <= 1'b0;
            st_q.msg_end <= 1'b0;
            st_q.rdata <= HSI_RDATA_RST;
            st_q.int_n <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign port_rdata = st_q.rdata;
    assign int_n = st_q.int_n;

    // Latched flags: set on the event, hold without a read, clear on a read
    // unless a new event lands in the same cycle
    AST_PKT_START_SET: assert property (@(posedge mclk) disable iff (rst)
        (ce && rx_open_byte) |=> flag_vec[HSI_BIT_RX_PKT_START])
        else $error("packet start flag missing after opening byte");

    AST_MSG_END_SET: assert property (@(posedge mclk) disable iff (rst)
        (ce && tx_frame_sent) |=> flag_vec[HSI_BIT_TX_MSG_END])
        else $error("message end flag missing after frame sent");

    AST_PKT_END_SET: assert property (@(posedge mclk) disable iff (rst)
        (ce && (rx_frame_good || rx_frame_fault)) |=> flag_vec[HSI_BIT_RX_PKT_END])
        else $error("packet end flag missing after frame end or fault");

    AST_STICKY_HOLD: assert property (@(posedge mclk) disable iff (rst)
        (ce && st_q.pkt_start && !rd_flags) |=> st_q.pkt_start)
        else $error("packet start flag dropped without a read");

    AST_PKT_END_HOLD: assert property (@(posedge mclk) disable iff (rst)
        (ce && st_q.pkt_end && !rd_flags) |=> st_q.pkt_end)
        else $error("packet end flag dropped without a read");

    AST_MSG_END_HOLD: assert property (@(posedge mclk) disable iff (rst)
        (ce && st_q.msg_end && !rd_flags) |=> st_q.msg_end)
        else $error("message end flag dropped without a read");

    AST_PKT_START_CLEAR: assert property (@(posedge mclk) disable iff (rst)
        (rd_flags && !rx_open_byte) |=> !st_q.pkt_start)
        else $error("packet start flag not cleared by flag read");

    AST_PKT_END_CLEAR: assert property (@(posedge mclk) disable iff (rst)
        (rd_flags && !rx_frame_good && !rx_frame_fault) |=> !st_q.pkt_end)
        else $error("packet end flag not cleared by flag read");

    AST_READ_CLEAR: assert property (@(posedge mclk) disable iff (rst)
        (rd_flags && !tx_frame_sent) |=> (!st_q.msg_end && (port_rdata[0] == $past(flag_vec[0]))))
        else $error("message end not cleared or not reported by flag read");

    AST_FREEZE_FLAGS: assert property (@(posedge mclk) disable iff (rst)
        (!rst && !ce) |=> ($stable(st_q.pkt_start) && $stable(st_q.pkt_end)
            && $stable(st_q.msg_end)))
        else $error("latched flag moved while clock enable low");

    // Register port: read data is captured at the strobe and then stands
    AST_WRITE_LANDS: assert property (@(posedge mclk) disable iff (rst)
        wr_enable |=> (st_q.enable == $past(port_wdata[6:0])))
        else $error("enable write did not land");

    AST_ENABLE_STABLE: assert property (@(posedge mclk) disable iff (rst)
        (!rst && !wr_enable) |=> $stable(st_q.enable))
        else $error("enable mask changed without a write");

    AST_READ_FLAGS_DATA: assert property (@(posedge mclk) disable iff (rst)
        rd_flags |=> (port_rdata == {1'b0, $past(flag_vec)}))
        else $error("flag read returned wrong data");

    AST_READ_ENABLE_DATA: assert property (@(posedge mclk) disable iff (rst)
        (ce && port_rd && port_addr == HSI_ADDR_ENABLE) |=> (port_rdata == {1'b0, $past(st_q.enable)}))
        else $error("enable read returned wrong data");

    AST_UNMAPPED_READ: assert property (@(posedge mclk) disable iff (rst)
        (ce && port_rd && port_addr != HSI_ADDR_FLAGS && port_addr != HSI_ADDR_ENABLE) |=> (port_rdata == 8'h00))
        else $error("unmapped read returned nonzero data");

    AST_RDATA_HOLD: assert property (@(posedge mclk) disable iff (rst)
        (!rst && !(ce && port_rd)) |=> $stable(port_rdata))
        else $error("read data changed without a read");

    // Interrupt pin: a flop, so each check looks one edge after its cause;
    // a cycle of latency is traded for a pin that never glitches
    AST_MASKED_QUIET: assert property (@(posedge mclk) disable iff (rst)
        (ce && ((flag_vec & st_q.enable) == 7'h00)) |=> int_n)
        else $error("interrupt asserted with no enabled flag");

    AST_ENABLED_FIRES: assert property (@(posedge mclk) disable iff (rst)
        (ce && ((flag_vec & st_q.enable) != 7'h00)) |=> !int_n)
        else $error("enabled flag did not pull interrupt low");

    AST_LOW_HAS_CAUSE: assert property (@(posedge mclk) disable iff (rst)
        !int_n |-> $past((flag_vec & st_q.enable) != 7'h00))
        else $error("interrupt low without an enabled flag behind it");

    // Level bits (mask 7'h1e) keep the pin low after a read, so they are left out
    AST_RELEASE_AFTER_READ: assert property (@(posedge mclk) disable iff (rst)
        (rd_flags && !wr_enable && ((st_q.enable & 7'h1e) == 7'h00) && !rx_open_byte
            && !rx_frame_good && !rx_frame_fault && !tx_frame_sent) ##1 ce |=> int_n)
        else $error("interrupt not released after reading latched flags");

    AST_FREEZE: assert property (@(posedge mclk) disable iff (rst)
        !ce |=> $stable(int_n) && $stable(port_rdata) && $stable(st_q.enable))
        else $error("state moved while clock enable low");

endmodule // hsi_top
`default_nettype wire

// ---- shared/hsi_pkg.sv ----
// Purpose: Constants shared by the HDLC status and interrupt mask block.
// Assumes: One framer, byte-wide control port synchronous to mclk.
// Notes: Register offsets are the port addresses of the two registers.
//
// Contract
// - Receive packet start flag rises when the receiver sees a frame's opening byte.
// - Both HDLC byte queues are 64 deep; thresholds come from that depth.
// - Transmit half empty flag is set while transmit occupancy is below midpoint.
// - Transmit message end flag rises when a whole frame has been sent.
// - Packet start, packet end, message end stay set until status register read.
// - Each status flag is gated by its own mask bit before the interrupt.
// - Enabled flag pulls interrupt low; released when flags read and none pending.
package hsi_pkg;

    // Register addresses on the control port
    localparam logic [7:0] HSI_ADDR_FLAGS = 8'hb1;
    localparam logic [7:0] HSI_ADDR_ENABLE = 8'hb2;

    // Bit positions shared by the flag and enable registers
    localparam int HSI_BIT_RX_PKT_END = 6;
    localparam int HSI_BIT_RX_PKT_START = 5;
    localparam int HSI_BIT_RX_HALF_FULL = 4;
    localparam int HSI_BIT_RX_NOT_EMPTY = 3;
    localparam int HSI_BIT_TX_HALF_EMPTY = 2;
    localparam int HSI_BIT_TX_NOT_FULL = 1;
    localparam int HSI_BIT_TX_MSG_END = 0;
    localparam int HSI_NUM_FLAGS = 7;

    // Queue geometry; occupancy counts 0..depth inclusive
    localparam int HSI_QUEUE_DEPTH = 64;
    localparam int HSI_LEVEL_W = 7;
    localparam logic [6:0] HSI_LEVEL_FULL = 7'h40;
    localparam logic [6:0] HSI_LEVEL_HALF = 7'h20;
    localparam logic [6:0] HSI_LEVEL_EMPTY = 7'h00;

    // Reset values
    localparam logic [6:0] HSI_ENABLE_RST = 7'h00;
    localparam logic [7:0] HSI_RDATA_RST = 8'h00;

endpackage : hsi_pkg

// ---- core/hsi_level_flags.sv ----
// Purpose: Derive the four queue-level flags from the queue occupancies.
// Assumes: Occupancy inputs come from logic on mclk, range 0..64.
// Notes: Flags are registered, so they trail the occupancy by one cycle.
`timescale 1ns/1ns
`default_nettype none
module hsi_level_flags
    import hsi_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [6:0] rx_level,
    input wire logic [6:0] tx_level,
    output logic rx_half_full,
    output logic rx_not_empty,
    output logic tx_half_empty,
    output logic tx_not_full
);

    typedef struct packed {
        logic rx_half;
        logic rx_ne;
        logic tx_half;
        logic tx_nf;
    } hsi_lvl_s;

    hsi_lvl_s st_q;
    hsi_lvl_s st_d;

    // Thresholds follow the level, no latching
    always_comb begin
        st_d = st_q;
        if (ce) begin
            st_d.rx_half = rx_level > HSI_LEVEL_HALF;
            st_d.rx_ne = rx_level != HSI_LEVEL_EMPTY;
            st_d.tx_half = tx_level < HSI_LEVEL_HALF;
            st_d.tx_nf = tx_level < HSI_LEVEL_FULL;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign rx_half_full = st_q.rx_half;
    assign rx_not_empty = st_q.rx_ne;
    assign tx_half_empty = st_q.tx_half;
    assign tx_not_full = st_q.tx_nf;

    // The sampled reset keeps the release edge out, where the flops still hold reset values
    AST_RX_HALF_THRESHOLD: assert property (@(posedge mclk) disable iff (rst)
        (!rst && ce) |=> (rx_half_full == ($past(rx_level) > HSI_LEVEL_HALF)))
        else $error("rx half full does not match occupancy above 32");

    AST_TX_HALF_THRESHOLD: assert property (@(posedge mclk) disable iff (rst)
        (!rst && ce) |=> (tx_half_empty == ($past(tx_level) < HSI_LEVEL_HALF)))
        else $error("tx half empty does not match occupancy below 32");

    AST_TX_NOT_FULL: assert property (@(posedge mclk) disable iff (rst)
        (ce && tx_level == HSI_LEVEL_FULL) |=> !tx_not_full)
        else $error("tx not full set with a full queue");

endmodule // hsi_level_flags
`default_nettype wire

// ---- dv/tb_top.sv ----
// Purpose: Self-checking bench for the HDLC event flags, enable mask and interrupt.
// Assumes: The bench stands in for the HDLC engines and the queues; all drive is on mclk.
// Notes: Level flags trail the queue levels by a cycle, so reads follow a level change.
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin n_fail++; \
    $display("Error t=%0t got %h exp %h", $time, got, exp); end end
module tb_top
    import hsi_pkg::*;
;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic port_rd = 1'b0;
    logic port_wr = 1'b0;
    logic [7:0] port_addr = 8'h00;
    logic [7:0] port_wdata = 8'h00;
    logic [7:0] port_rdata;
    logic [3:0] ev = 4'h0;
    logic [6:0] rx_level = 7'h00;
    logic [6:0] tx_level = 7'h00;
    logic int_n;
    logic [7:0] ebit [4] = '{8'h20, 8'h40, 8'h40, 8'h01};
    int n_fail = 0;
    int compares = 0;
    int cyc = 0;

    // 20 MHz clock
    always #25 mclk = ~mclk;

    hsi_top dut (.mclk(mclk), .rst(rst), .ce(ce), .port_rd(port_rd), .port_wr(port_wr), .port_addr(port_addr),
        .port_wdata(port_wdata), .port_rdata(port_rdata), .rx_open_byte(ev[0]), .rx_frame_good(ev[1]),
        .rx_frame_fault(ev[2]), .tx_frame_sent(ev[3]), .rx_level(rx_level), .tx_level(tx_level), .int_n(int_n));

    // Verdict; also the landing point when the cycle ceiling cuts a hang short
    task automatic test_done;
        $display("Counts: compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Whole run needs about 110 cycles; the ceiling leaves ample margin
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            test_done();
        end
    end

    // Let n edges pass, then sample settled outputs
    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // One write strobe, held for exactly one taken edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        port_wr <= 1'b1;
        port_addr <= a;
        port_wdata <= d;
        @(posedge mclk);
        port_wr <= 1'b0;
    endtask

    // One read strobe; data is registered at the taking edge
    task automatic rdreg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk);
        port_rd <= 1'b1;
        port_addr <= a;
        @(posedge mclk);
        port_rd <= 1'b0;
        #1;
        `CHK(port_rdata, exp)
    endtask

    task automatic pulse(input int k);
        @(posedge mclk);
        ev[k] <= 1'b1;
        @(posedge mclk);
        ev[k] <= 1'b0;
    endtask

    task automatic lv(input logic [6:0] r, input logic [6:0] t, input logic [7:0] exp);
        @(posedge mclk);
        rx_level <= r;
        tx_level <= t;
        rdreg(HSI_ADDR_FLAGS, exp);
    endtask

    task automatic t_reset;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        #1;
        `CHK(port_rdata, 8'h00)
        `CHK(int_n, 1'b1)
        rdreg(HSI_ADDR_ENABLE, 8'h00);
        rdreg(HSI_ADDR_FLAGS, 8'h06);
        $display("test reset done");
    endtask

    // Bit 7 and unmapped places hold nothing
    task automatic t_regs;
        wr(HSI_ADDR_ENABLE, 8'hff);
        rdreg(HSI_ADDR_ENABLE, 8'h7f);
        wr(8'hb0, 8'h00);
        rdreg(8'hb5, 8'h00);
        rdreg(HSI_ADDR_ENABLE, 8'h7f);
        wr(HSI_ADDR_ENABLE, 8'h00);
        $display("test regs done");
    endtask

    // Thresholds at the midpoint and at the full depth of 64
    task automatic t_levels;
        lv(7'd1, 7'd63, 8'h0a);
        lv(7'd32, 7'd32, 8'h0a);
        lv(7'd33, 7'd31, 8'h1e);
        lv(7'd64, 7'd64, 8'h18);
        lv(7'd0, 7'd0, 8'h06);
        $display("test levels done");
    endtask

    task automatic t_sticky;
        for (int k = 0; k < 4; k++) begin
            pulse(k);
            settle(3);
            rdreg(HSI_ADDR_FLAGS, 8'h06 | ebit[k]);
            rdreg(HSI_ADDR_FLAGS, 8'h06);
        end
        // An event coincident with the clearing read survives it
        @(posedge mclk);
        port_rd <= 1'b1;
        port_addr <= HSI_ADDR_FLAGS;
        ev[0] <= 1'b1;
        @(posedge mclk);
        port_rd <= 1'b0;
        ev[0] <= 1'b0;
        #1;
        `CHK(port_rdata, 8'h06)
        rdreg(HSI_ADDR_FLAGS, 8'h26);
        $display("test sticky done");
    endtask

    task automatic t_irq;
        wr(HSI_ADDR_ENABLE, 8'h20);
        pulse(0);
        settle(1);
        `CHK(int_n, 1'b0)
        rdreg(HSI_ADDR_FLAGS, 8'h26);
        settle(1);
        `CHK(int_n, 1'b1)
        lv(7'd0, 7'd64, 8'h00);
        wr(HSI_ADDR_ENABLE, 8'h5f);
        pulse(0);
        settle(2);
        `CHK(int_n, 1'b1)
        rdreg(HSI_ADDR_FLAGS, 8'h20);
        wr(HSI_ADDR_ENABLE, 8'h04);
        lv(7'd0, 7'd0, 8'h06);
        settle(1);
        `CHK(int_n, 1'b0)
        lv(7'd0, 7'd40, 8'h02);
        settle(1);
        `CHK(int_n, 1'b1)
        $display("test irq done");
    endtask

    // With the clock enable low, strobes and events are lost
    task automatic t_ce;
        @(posedge mclk);
        ce <= 1'b0;
        pulse(0);
        wr(HSI_ADDR_ENABLE, 8'h7f);
        @(posedge mclk);
        ce <= 1'b1;
        rdreg(HSI_ADDR_FLAGS, 8'h02);
        rdreg(HSI_ADDR_ENABLE, 8'h04);
        $display("test ce done");
    endtask

    initial begin
        t_reset();
        t_regs();
        t_levels();
        t_sticky();
        t_irq();
        t_ce();
        test_done();
    end
endmodule // tb_top
`default_nettype wire
